// file: hw/ccr_defs.svh
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

// instruction word layout
`define CCR_IW 14
`define CCR_ZF_MATCH 7'h03
`define CCR_ZF_TOP 13
`define CCR_ZF_BOT 7
`define CCR_ZA_WORD 14'h0103
`define CCR_CALL_MATCH 3'h4
`define CCR_CALL_TOP 13
`define CCR_CALL_BOT 11
`define CCR_RET_WORD 14'h0008
`define CCR_RR_MATCH 6'h0c
`define CCR_RR_TOP 13
`define CCR_RR_BOT 8
`define CCR_DEST_BIT 7
`define CCR_FADDR_TOP 6
`define CCR_IMM_TOP 10

// program counter and stack
`define CCR_PCW 13
`define CCR_PC_RST 13'h0000
`define CCR_UPH_HI 4
`define CCR_UPH_LO 3
`define CCR_STK_DEPTH 8
`define CCR_STK_PW 3

// register offsets (byte addresses)
`define CCR_OFF_ACC 8'h00
`define CCR_OFF_STAT 8'h04
`define CCR_OFF_UPH 8'h08
`define CCR_OFF_PC 8'h0c
`define CCR_OFF_HEAD 8'h10
`define CCR_OFF_SPTR 8'h14

// status bit positions and reset values
`define CCR_STAT_C 0
`define CCR_STAT_Z 2
`define CCR_ACC_RST 8'h00
`define CCR_STAT_RST 8'h00
`define CCR_UPH_RST 8'h00

`endif

// file: hw/ccr_pkg.sv
package ccr_pkg;

  typedef enum logic [1:0] {
    CCR_IDLE = 2'b00,
    CCR_ROT_RD = 2'b01,
    CCR_DUMMY = 2'b10
  } ccr_state_e;

  typedef enum logic [2:0] {
    CCR_OP_NONE = 3'h0,
    CCR_OP_ZFILE = 3'h1,
    CCR_OP_ZACC = 3'h2,
    CCR_OP_CALL = 3'h3,
    CCR_OP_RET = 3'h4,
    CCR_OP_ROT = 3'h5
  } ccr_op_e;

  typedef struct packed {
    ccr_op_e op;
    logic [6:0] faddr;
    logic dest;
    logic [10:0] imm;
  } ccr_dec_s;

  typedef struct packed {
    logic valid;
    logic [13:0] word;
  } ccr_instr_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ccr_bus_s;

endpackage

// file: hw/ccr_file_mem.sv
`timescale 1ns/1ps
`include "ccr_defs.svh"

module ccr_file_mem (
  // clock
  input wire logic ref_clk,
  // write side
  input wire logic wr_en,
  input wire logic [6:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read side
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:127];

  // write port
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read port
  always_ff @(posedge ref_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule

// file: hw/ccr_exec.sv
`timescale 1ns/1ps
`include "ccr_defs.svh"

// Behaviour
// - zero_file_op writes 00h to file register 0..127 and sets zero flag
// - call first pushes program counter plus one onto return stack
// - call loads 11-bit immediate into program counter bits 10:0
// - call takes pc bits 12:11 from upper_pc_holding bits 4:3
// - call takes two instruction cycles and leaves status flags alone
// - zero_acc_op clears accumulator, sets zero flag, one cycle
// - return pops stack, loads stack_head into pc, takes two cycles
// - rotate_right_op shifts file right through carry; dest 0 acc, 1 file

module ccr_exec (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // instruction stream
  input ccr_pkg::ccr_instr_s instr,
  output logic instr_ready,
  // register port
  input ccr_pkg::ccr_bus_s bus,
  output logic [7:0] bus_rdata,
  // visible core state
  output logic [12:0] pc_out,
  output logic [7:0] acc_out,
  output logic zero_flag,
  output logic carry_flag
);
  import ccr_pkg::*;

  // decode one program word into an operation and its fields
  function automatic ccr_dec_s ccr_decode(input logic [13:0] w);
    ccr_dec_s d;
    d.op = CCR_OP_NONE;
    d.faddr = w[`CCR_FADDR_TOP:0];
    d.dest = w[`CCR_DEST_BIT];
    d.imm = w[`CCR_IMM_TOP:0];
    if (w == `CCR_ZA_WORD) begin
      d.op = CCR_OP_ZACC;
    end else if (w == `CCR_RET_WORD) begin
      d.op = CCR_OP_RET;
    end else if (w[`CCR_ZF_TOP:`CCR_ZF_BOT] == `CCR_ZF_MATCH) begin
      d.op = CCR_OP_ZFILE;
    end else if (w[`CCR_CALL_TOP:`CCR_CALL_BOT] == `CCR_CALL_MATCH) begin
      d.op = CCR_OP_CALL;
    end else if (w[`CCR_RR_TOP:`CCR_RR_BOT] == `CCR_RR_MATCH) begin
      d.op = CCR_OP_ROT;
    end
    return d;
  endfunction

  // register decode, used for writes and reads
  function automatic logic ccr_hit(input logic [7:0] a,
                                   input logic [7:0] off);
    return a == off;
  endfunction

  ccr_state_e state_reg;
  ccr_state_e state_next;
  logic ready_reg;
  logic ready_next;
  logic [12:0] pc_reg;
  logic [7:0] acc_reg;
  logic [7:0] stat_reg;
  logic [7:0] uph_reg;
  logic [7:0] rdata_reg;
  logic [2:0] sptr_reg;
  logic [12:0] stk_reg [0:`CCR_STK_DEPTH-1];
  logic [12:0] stack_head;
  logic [12:0] pc_inc;
  logic [6:0] rot_addr_reg;
  logic rot_dest_reg;
  logic [7:0] mem_rdata;
  logic [7:0] rot_result;
  logic take;
  logic push;
  logic pop;
  logic mem_wr;
  logic [6:0] mem_waddr;
  logic [7:0] mem_wdata;
  ccr_dec_s dec;

  // accept an instruction when ready, then decode it
  assign take = instr.valid & ready_reg;
  assign dec = ccr_decode(instr.word);
  assign pc_inc = pc_reg + 13'h0001;
  assign stack_head = stk_reg[sptr_reg - 3'h1];
  assign push = take && dec.op == CCR_OP_CALL;
  assign pop = take && dec.op == CCR_OP_RET;

  // rotate result: carry enters at the top, bit 0 leaves to carry
  assign rot_result = {stat_reg[`CCR_STAT_C], mem_rdata[7:1]};

  // the memory has one write port; no take is seen while a rotate
  // result is pending, so the two writers never collide
  // file register write: zero on clear, rotate result on dest 1
  always_comb begin
    mem_wr = 1'b0;
    mem_waddr = dec.faddr;
    mem_wdata = 8'h00;
    if (take && dec.op == CCR_OP_ZFILE) begin
      mem_wr = 1'b1;
    end else if (state_reg == CCR_ROT_RD && rot_dest_reg) begin
      mem_wr = 1'b1;
      mem_waddr = rot_addr_reg;
      mem_wdata = rot_result;
    end
  end

  // reads follow the offered word so the rotate operand is ready in time
  ccr_file_mem u_mem (
    .ref_clk(ref_clk),
    .wr_en(mem_wr),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_addr(dec.faddr),
    .rd_data(mem_rdata)
  );

  // call and return spend their second cycle idle; rotate spends it
  // on the write-back of its result
  // sequencing: two-cycle ops hold off the next instruction one cycle
  always_comb begin
    state_next = state_reg;
    ready_next = ready_reg;
    case (state_reg)
      CCR_IDLE: begin
        if (take) begin
          if (dec.op == CCR_OP_CALL || dec.op == CCR_OP_RET) begin
            state_next = CCR_DUMMY;
            ready_next = 1'b0;
          end else if (dec.op == CCR_OP_ROT) begin
            state_next = CCR_ROT_RD;
            ready_next = 1'b0;
          end
        end
      end
      CCR_ROT_RD: begin
        state_next = CCR_IDLE;
        ready_next = 1'b1;
      end
      CCR_DUMMY: begin
        state_next = CCR_IDLE;
        ready_next = 1'b1;
      end
      default: begin
        state_next = CCR_IDLE;
        ready_next = 1'b1;
      end
    endcase
  end

  // state and ready flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= CCR_IDLE;
      ready_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      ready_reg <= ready_next;
    end
  end

  // the file read is registered, so the operand lands a cycle after the
  // take; address and destination are kept for the write-back then
  // rotate operand capture
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rot_addr_reg <= 7'h00;
      rot_dest_reg <= 1'b0;
    end else if (take && dec.op == CCR_OP_ROT) begin
      rot_addr_reg <= dec.faddr;
      rot_dest_reg <= dec.dest;
    end
  end

  // rotate holds the pc on the take and steps it when the result lands,
  // so the pc points at the next word once ready is back
  // program counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg <= `CCR_PC_RST;
    end else if (take) begin
      case (dec.op)
        CCR_OP_CALL: begin
          pc_reg <= {uph_reg[`CCR_UPH_HI:`CCR_UPH_LO], dec.imm};
        end
        CCR_OP_RET: begin
          pc_reg <= stack_head;
        end
        CCR_OP_ROT: begin
          pc_reg <= pc_reg;
        end
        default: begin
          pc_reg <= pc_inc;
        end
      endcase
    end else if (state_reg == CCR_ROT_RD) begin
      pc_reg <= pc_inc;
    end
  end

  // return stack pointer: push before the jump, pop on return
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sptr_reg <= 3'h0;
    end else if (push) begin
      sptr_reg <= sptr_reg + 3'h1;
    end else if (pop) begin
      sptr_reg <= sptr_reg - 3'h1;
    end
  end

  // overflow silently overwrites the oldest entry and underflow wraps;
  // software can watch the pointer register to spot either
  // return stack entries, circular
  genvar gi;
  generate
    for (gi = 0; gi < `CCR_STK_DEPTH; gi = gi + 1) begin : g_stk
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          stk_reg[gi] <= 13'h0000;
        end else if (push && sptr_reg == 3'(gi)) begin
          stk_reg[gi] <= pc_inc;
        end
      end
    end
  endgenerate

  // a software write loses to an instruction update in the same cycle
  // accumulator: cleared, rotate result on dest 0, or software write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= `CCR_ACC_RST;
    end else if (take && dec.op == CCR_OP_ZACC) begin
      acc_reg <= 8'h00;
    end else if (state_reg == CCR_ROT_RD && !rot_dest_reg) begin
      acc_reg <= rot_result;
    end else if (bus.wr && ccr_hit(bus.addr, `CCR_OFF_ACC)) begin
      acc_reg <= bus.wdata;
    end
  end

  // instruction updates win over a software write in the same cycle
  // status: zero on clears, carry on rotate; calls leave it alone
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= `CCR_STAT_RST;
    end else if (take && (dec.op == CCR_OP_ZFILE ||
                          dec.op == CCR_OP_ZACC)) begin
      stat_reg[`CCR_STAT_Z] <= 1'b1;
    end else if (state_reg == CCR_ROT_RD) begin
      stat_reg[`CCR_STAT_C] <= mem_rdata[0];
    end else if (bus.wr && ccr_hit(bus.addr, `CCR_OFF_STAT)) begin
      stat_reg <= bus.wdata;
    end
  end

  // upper pc holding register, software written
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      uph_reg <= `CCR_UPH_RST;
    end else if (bus.wr && ccr_hit(bus.addr, `CCR_OFF_UPH)) begin
      uph_reg <= bus.wdata;
    end
  end

  // pc and stack head are wider than a byte; only the low byte is mapped
  // read data, one cycle after the read strobe, zero elsewhere
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (bus.rd) begin
      if (ccr_hit(bus.addr, `CCR_OFF_ACC)) begin
        rdata_reg <= acc_reg;
      end else if (ccr_hit(bus.addr, `CCR_OFF_STAT)) begin
        rdata_reg <= stat_reg;
      end else if (ccr_hit(bus.addr, `CCR_OFF_UPH)) begin
        rdata_reg <= uph_reg;
      end else if (ccr_hit(bus.addr, `CCR_OFF_PC)) begin
        rdata_reg <= pc_reg[7:0];
      end else if (ccr_hit(bus.addr, `CCR_OFF_HEAD)) begin
        rdata_reg <= stack_head[7:0];
      end else if (ccr_hit(bus.addr, `CCR_OFF_SPTR)) begin
        rdata_reg <= {5'h00, sptr_reg};
      end else begin
        rdata_reg <= 8'h00;
      end
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // outputs straight from flops
  assign instr_ready = ready_reg;
  assign bus_rdata = rdata_reg;
  assign pc_out = pc_reg;
  assign acc_out = acc_reg;
  assign zero_flag = stat_reg[`CCR_STAT_Z];
  assign carry_flag = stat_reg[`CCR_STAT_C];
endmodule

// file: testbench/ccr_exec_monitor.sv
`timescale 1ns/1ps
module ccr_exec_monitor
  import ccr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // instruction stream
  input ccr_pkg::ccr_instr_s instr,
  input wire logic instr_ready,
  // register port
  input ccr_pkg::ccr_bus_s bus,
  input wire logic [7:0] bus_rdata,
  // core state
  input wire logic [12:0] pc_out,
  input wire logic [7:0] acc_out,
  input wire logic zero_flag,
  input wire logic carry_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic take;
  logic [13:0] w;
  logic [13:0] w_q;
  // accepted instruction and its word
  assign take = instr.valid && instr_ready;
  assign w = instr.word;
  // word of the previous cycle
  always_ff @(posedge ref_clk) begin
    w_q <= w;
  end
  sequence s_stall;
    !instr_ready ##1 instr_ready;
  endsequence
  property p_zacc;
    take && w == 14'h0103 |=> acc_out == 8'h00 && zero_flag;
  endproperty
  property p_zacc_pc;
    take && w == 14'h0103 |=> pc_out == $past(pc_out) + 13'h0001;
  endproperty
  property p_zfile;
    take && w[13:7] == 7'h03 |=> zero_flag;
  endproperty
  property p_call_stall;
    take && w[13:11] == 3'h4 |=> s_stall;
  endproperty
  property p_call_flags;
    take && w[13:11] == 3'h4 |=>
      ($stable(zero_flag) && $stable(carry_flag)) [*2];
  endproperty
  property p_call_pc;
    take && w[13:11] == 3'h4 |=> pc_out[10:0] == w_q[10:0];
  endproperty
  property p_ret;
    take && w == 14'h0008 |=> s_stall;
  endproperty
  property p_rot;
    take && w[13:8] == 6'h0c && !w[7] |=> !instr_ready ##1
      (instr_ready && acc_out[7] == $past(carry_flag));
  endproperty
  property p_rot_z;
    take && w[13:8] == 6'h0c |=> $stable(zero_flag) [*2];
  endproperty
  a_zacc: assert property (p_zacc) else $error("zacc");
  a_zacc_pc: assert property (p_zacc_pc) else $error("pc step");
  a_zfile: assert property (p_zfile) else $error("zfile");
  a_call_stall: assert property (p_call_stall) else $error("cs");
  a_call_flags: assert property (p_call_flags) else $error("cf");
  a_call_pc: assert property (p_call_pc) else $error("call pc");
  a_ret: assert property (p_ret) else $error("ret");
  a_rot: assert property (p_rot) else $error("rot");
  a_rot_z: assert property (p_rot_z) else $error("rot z");
endmodule

bind ccr_exec ccr_exec_monitor u_mon (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .instr(instr),
  .instr_ready(instr_ready),
  .bus(bus),
  .bus_rdata(bus_rdata),
  .pc_out(pc_out),
  .acc_out(acc_out),
  .zero_flag(zero_flag),
  .carry_flag(carry_flag)
);

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ccr_pkg::*;
  logic ref_clk;
  logic rst_n;
  ccr_instr_s instr;
  ccr_bus_s bus;
  logic instr_ready;
  logic [7:0] bus_rdata;
  logic [12:0] pc_out;
  logic [7:0] acc_out;
  logic zero_flag;
  logic carry_flag;
  int n_mismatch;
  int checked;

  ccr_exec DUT (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .instr(instr),
    .instr_ready(instr_ready),
    .bus(bus),
    .bus_rdata(bus_rdata),
    .pc_out(pc_out),
    .acc_out(acc_out),
    .zero_flag(zero_flag),
    .carry_flag(carry_flag)
  );

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus <= '0;
  endtask

  // one register read, data judged in the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus <= '0;
    #1;
    chk(bus_rdata, e);
  endtask

  // offer one word and wait until the core accepts again
  task automatic ex(input logic [13:0] word);
    int n;
    n = 0;
    @(posedge ref_clk);
    instr <= '{valid: 1'b1, word: word};
    @(posedge ref_clk);
    instr.valid <= 1'b0;
    #1;
    while (instr_ready !== 1'b1 && n < 4) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(instr_ready, 1'b1);
  endtask

  // clearing the accumulator
  task automatic t_zacc();
    wr(8'h00, 8'h5a);
    rd(8'h00, 8'h5a);
    ex(14'h0103);
    chk(acc_out, 8'h00);
    chk(pc_out, 13'h0001);
    rd(8'h04, 8'h04);
  endtask

  // clearing a file register seen through rotates
  task automatic t_rot();
    wr(8'h04, 8'h01);
    ex({7'h03, 7'h7f});
    chk(zero_flag, 1'b1);
    ex({6'h0c, 1'b0, 7'h7f});
    chk({carry_flag, acc_out}, 9'h080);
    wr(8'h04, 8'h05);
    ex({6'h0c, 1'b1, 7'h7f});
    chk(acc_out, 8'h80);
    ex({6'h0c, 1'b0, 7'h7f});
    chk({carry_flag, acc_out}, 9'h040);
    chk(pc_out, 13'h0005);
    wr(8'h0c, 8'hff);
    rd(8'h0c, 8'h05);
    rd(8'h20, 8'h00);
  endtask

  // call then return
  task automatic t_call();
    wr(8'h08, 8'h18);
    ex({3'h4, 11'h5a5});
    chk(pc_out, 13'h1da5);
    rd(8'h10, 8'h06);
    rd(8'h14, 8'h01);
    rd(8'h04, 8'h04);
    ex(14'h0008);
    chk(pc_out, 13'h0006);
    rd(8'h14, 8'h00);
  endtask

  // carry out of bit 0 after walking a one down a file register
  task automatic t_carry();
    repeat (7) ex({6'h0c, 1'b1, 7'h7f});
    ex({6'h0c, 1'b0, 7'h7f});
    chk({carry_flag, acc_out}, 9'h100);
    chk(zero_flag, 1'b1);
    chk(pc_out, 13'h000e);
  endtask

  // watchdog
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end

  // main sequence
  initial begin
    n_mismatch = 0;
    checked = 0;
    rst_n = 1'b0;
    instr = '0;
    bus = '0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_zacc();
    t_rot();
    t_call();
    t_carry();
    test_done();
  end
endmodule
